// *** fpc_core_model.sv ***
// fpc_core_model: core side issuing commands, reads and settings
// assumes: fpc_ctrl samples on rising edges; this model drives on falling ones
`timescale 1ns/100ps
`default_nettype none
module fpc_core_model (
	// clock
	input  wire logic        clk_sys_i,
	// requests toward the controller
	output logic      [7:0]  usec_o,
	output logic             usec_ld_o,
	output logic             prog_o,
	output logic             erase_o,
	output logic      [13:0] addr_o,
	output logic      [31:0] data_o,
	output logic             rd_o,
	output logic             fetch_o,
	output logic      [13:0] raddr_o,
	output logic             pset_o,
	output logic      [2:0]  preg_o,
	output logic      [1:0]  pval_o,
	output logic             commit_o,
	output logic      [1:0]  clr_o
);
	initial {usec_o, usec_ld_o, prog_o, erase_o, addr_o, data_o, rd_o, fetch_o, raddr_o,
		pset_o, preg_o, pval_o, commit_o, clr_o} = '0;
	// released strobes drop to 0 and other lines go inverted, so nothing stale looks valid
	task automatic cmd(input logic er, input logic [13:0] a, input logic [31:0] d);
		@(negedge clk_sys_i);
		{prog_o, erase_o, addr_o, data_o} <= {!er, er, a[13:2], 2'b00, d};
		@(negedge clk_sys_i);
		{prog_o, erase_o, addr_o, data_o} <= {2'b00, ~addr_o, ~data_o};
	endtask : cmd
	task automatic rd(input logic f, input logic [13:0] a);
		@(negedge clk_sys_i);
		{rd_o, fetch_o, raddr_o} <= {1'b1, f, a};
		@(negedge clk_sys_i);
		{rd_o, fetch_o, raddr_o} <= {1'b0, ~f, ~a};
	endtask : rd
	task automatic prot(input logic s, input logic [2:0] r, input logic [1:0] v);
		@(negedge clk_sys_i);
		{pset_o, commit_o, preg_o, pval_o} <= {s, !s, r, v};
		@(negedge clk_sys_i);
		{pset_o, commit_o, preg_o, pval_o} <= {2'b00, ~r, ~v};
	endtask : prot
	// clear goes out for one cycle; a flag set in that same cycle still wins
	task automatic clear(input logic [1:0] m);
		@(negedge clk_sys_i);
		clr_o <= m;
		@(negedge clk_sys_i);
		clr_o <= 2'b00;
	endtask : clear
	task automatic usec(input logic [7:0] u);
		@(negedge clk_sys_i);
		{usec_ld_o, usec_o} <= {1'b1, u};
		@(negedge clk_sys_i);
		{usec_ld_o, usec_o} <= {1'b0, ~u};
	endtask : usec
endmodule : fpc_core_model
`default_nettype wire

// *** fpc_ctrl.sv ***
// fpc_ctrl: flash array, program/erase sequencer, region protection, interrupts
// assumes: all inputs come from logic on clk_sys_i; one command pulse at a time
//
// Contract
// - erase works per 1 kB block only
// - erased block reads back all ones
// - protection per 2 kB pair of blocks
// - read-only: refuse writes, allow reads and fetches
// - execute-only: fetch only, refuse everything else
// - program one 32-bit word per operation
// - programming only clears bits (AND)
// - clocks-per-microsecond times program/erase pulses
// - invalid access sets violation flag
// - finished erase/program sets done flag
// - protection immediate, commit irreversible
// - clear request deasserts interrupt source
// - per-source mask gates interrupt output
// - raw and masked status both readable
// - status: bit0 done, bit1 violation
// - protection never loosened; exec-only frozen; reset returns uncommitted regions to read/write
`timescale 1ns/100ps
`default_nettype none
module fpc_ctrl (
	// clock and reset
	input  wire logic                      clk_sys_i,
	input  wire logic                      resetn_i,
	// timing configuration
	input  wire logic [7:0]                usec_clocks_i,
	input  wire logic                      usec_load_i,
	output logic      [7:0]                usec_clocks_o,
	// program / erase commands
	input  wire logic                      prog_req_i,
	input  wire logic                      erase_req_i,
	input  wire logic [fpc_pkg::ADDR_W-1:0] cmd_addr_i,
	input  wire logic [31:0]               prog_data_i,
	output logic                           busy_o,
	// read / fetch port
	input  wire logic                      rd_req_i,
	input  wire logic                      rd_fetch_i,
	input  wire logic [fpc_pkg::ADDR_W-1:0] rd_addr_i,
	output logic      [31:0]               rd_data_o,
	output logic                           rd_valid_o,
	output logic                           rd_blocked_o,
	// protection
	input  wire logic                      prot_set_i,
	input  wire logic [fpc_pkg::REG_W-1:0] prot_region_i,
	input  wire logic [1:0]                prot_value_i,
	input  wire logic                      prot_commit_i,
	output logic      [2*fpc_pkg::REGIONS-1:0] prot_o,
	output logic                           prot_committed_o,
	// interrupts
	input  wire logic [1:0]                irq_clear_i,
	input  wire logic                      done_irq_mask_bit,
	input  wire logic                      violation_irq_mask_bit,
	output logic      [1:0]                irq_raw_o,
	output logic      [1:0]                irq_masked_o,
	output logic                           irq_o
);
	// ----------------------------------------
	// storage and state
	// ----------------------------------------
	logic [31:0]              mem [fpc_pkg::WORDS];
	logic [1:0]               prot_reg [fpc_pkg::REGIONS];
	// fresh part: nothing committed; stands in for the non-volatile commit bit
	logic                     commit_reg = 1'b0;
	logic [7:0]               usec_reg;
	fpc_pkg::fpc_state_e      state_reg;
	logic [7:0]               clk_cnt_reg;
	logic [15:0]              us_cnt_reg;
	logic [fpc_pkg::WADDR_W-1:0] op_addr_reg;
	logic [31:0]              op_data_reg;
	logic                     done_reg;
	logic                     viol_reg;
	logic [31:0]              rd_data_reg;
	logic                     rd_valid_reg;
	logic                     rd_blocked_reg;

	function automatic logic [fpc_pkg::REG_W-1:0] region_of(input logic [fpc_pkg::ADDR_W-1:0] a);
		region_of = a[fpc_pkg::ADDR_W-1 -: fpc_pkg::REG_W];
	endfunction : region_of

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire logic [1:0] cmd_prot  = prot_reg[region_of(cmd_addr_i)];
	wire logic [1:0] rd_prot   = prot_reg[region_of(rd_addr_i)];
	wire logic       cmd_req   = prog_req_i | erase_req_i;
	wire logic       cmd_ok    = cmd_prot == fpc_pkg::protect_read_write;
	wire logic       cmd_take  = cmd_req && state_reg == fpc_pkg::FPC_IDLE;
	wire logic       cmd_go    = cmd_take && cmd_ok;
	wire logic       cmd_viol  = cmd_take && !cmd_ok;
	wire logic       rd_deny   = rd_req_i && !rd_fetch_i &&
	                             rd_prot == fpc_pkg::protect_exec_only;
	// only equal or stricter settings pass; unknown codes are refused
	wire logic       prot_ok   = prot_value_i >= prot_reg[prot_region_i] &&
	                             prot_value_i <= fpc_pkg::protect_exec_only &&
	                             prot_reg[prot_region_i] != fpc_pkg::protect_exec_only;
	wire logic       us_tick   = clk_cnt_reg == usec_reg - 8'h01 || usec_reg == 8'h00;
	wire logic [15:0] us_limit = state_reg == fpc_pkg::FPC_ERASE ? fpc_pkg::ERASE_US
	                                                              : fpc_pkg::PROG_US;
	wire logic       op_end    = state_reg != fpc_pkg::FPC_IDLE && us_tick &&
	                             us_cnt_reg == us_limit - 16'h0001;
	wire logic       rd_inval  = rd_deny;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			state_reg   <= fpc_pkg::FPC_IDLE;
			clk_cnt_reg <= 8'h00;
			us_cnt_reg  <= 16'h0000;
			op_addr_reg <= '0;
			op_data_reg <= 32'h0000_0000;
		end else if (cmd_go) begin
			state_reg   <= prog_req_i ? fpc_pkg::FPC_PROG : fpc_pkg::FPC_ERASE;
			clk_cnt_reg <= 8'h00;
			us_cnt_reg  <= 16'h0000;
			op_addr_reg <= cmd_addr_i[fpc_pkg::ADDR_W-1:2];
			op_data_reg <= prog_data_i;
		end else if (op_end) begin
			state_reg <= fpc_pkg::FPC_IDLE;
		end else if (state_reg != fpc_pkg::FPC_IDLE) begin
			// counters freeze in idle; the next accepted command restarts them
			clk_cnt_reg <= us_tick ? 8'h00 : clk_cnt_reg + 8'h01;
			us_cnt_reg  <= us_tick ? us_cnt_reg + 16'h0001 : us_cnt_reg;
		end
	end

	// ----------------------------------------
	// array update at end of pulse
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < fpc_pkg::WORDS; gi++) begin : g_word
			localparam logic [fpc_pkg::WADDR_W-1:0] WORD_IX = (fpc_pkg::WADDR_W)'(gi);
			wire logic in_blk = WORD_IX[fpc_pkg::WADDR_W-1:fpc_pkg::ERASE_LSB] ==
			                    op_addr_reg[fpc_pkg::WADDR_W-1:fpc_pkg::ERASE_LSB];
			always_ff @(posedge clk_sys_i) begin
				if (op_end && state_reg == fpc_pkg::FPC_ERASE && in_blk) begin
					mem[gi] <= fpc_pkg::ERASED_WORD;
				end else if (op_end && state_reg == fpc_pkg::FPC_PROG &&
				             op_addr_reg == WORD_IX) begin
					mem[gi] <= mem[gi] & op_data_reg;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// protection and timing configuration
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			usec_reg   <= fpc_pkg::USEC_RST;
		end else begin
			if (prot_commit_i)
				commit_reg <= 1'b1;
			if (usec_load_i && state_reg == fpc_pkg::FPC_IDLE)
				usec_reg <= usec_clocks_i;
		end
	end

	// committed settings survive reset; uncommitted ones fall back to read/write
	generate
		for (gi = 0; gi < fpc_pkg::REGIONS; gi++) begin : g_prot
			localparam logic [fpc_pkg::REG_W-1:0] REGION_IX = (fpc_pkg::REG_W)'(gi);
			always_ff @(posedge clk_sys_i) begin
				if (!resetn_i && !commit_reg) begin
					prot_reg[gi] <= fpc_pkg::protect_read_write;
				end else if (resetn_i && prot_set_i && prot_ok &&
				             prot_region_i == REGION_IX) begin
					prot_reg[gi] <= prot_value_i;
				end
			end
			assign prot_o[2*gi +: 2] = prot_reg[gi];
			a_no_loosen: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
				prot_reg[gi] == fpc_pkg::protect_exec_only |=>
				prot_reg[gi] == fpc_pkg::protect_exec_only)
				else $error("exec-only region changed");
			a_no_weaken: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
				prot_set_i && prot_region_i == REGION_IX && prot_value_i < prot_reg[gi] |=>
				$stable(prot_reg[gi]))
				else $error("protection loosened");
		end
	endgenerate

	// ----------------------------------------
	// reads
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			rd_data_reg    <= 32'h0000_0000;
			rd_valid_reg   <= 1'b0;
			rd_blocked_reg <= 1'b0;
		end else begin
			rd_valid_reg   <= rd_req_i && !rd_deny;
			rd_blocked_reg <= rd_deny;
			// blocked reads return zero so protected words never leak
			if (rd_req_i)
				rd_data_reg <= rd_deny ? 32'h0000_0000 : mem[rd_addr_i[fpc_pkg::ADDR_W-1:2]];
		end
	end

	// ----------------------------------------
	// interrupt flags: set wins over clear
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			done_reg <= 1'b0;
			viol_reg <= 1'b0;
		end else begin
			done_reg <= op_end | (done_reg & ~irq_clear_i[fpc_pkg::DONE_BIT]);
			viol_reg <= cmd_viol | rd_inval |
			            (viol_reg & ~irq_clear_i[fpc_pkg::VIOL_BIT]);
		end
	end

	wire logic [1:0] irq_mask = {violation_irq_mask_bit, done_irq_mask_bit};
	assign irq_raw_o        = {viol_reg, done_reg};
	assign irq_masked_o     = irq_raw_o & irq_mask;
	assign irq_o            = |irq_masked_o;
	assign busy_o           = state_reg != fpc_pkg::FPC_IDLE;
	assign usec_clocks_o    = usec_reg;
	assign prot_committed_o = commit_reg;
	assign rd_data_o        = rd_data_reg;
	assign rd_valid_o       = rd_valid_reg;
	assign rd_blocked_o     = rd_blocked_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_busy_ignores: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		busy_o && cmd_req |=> $stable(op_addr_reg))
		else $error("command taken while busy");
	a_viol_on_refuse: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		cmd_take && !cmd_ok |=> irq_raw_o[1] && !busy_o)
		else $error("refused command did not flag violation");
	a_exec_read_block: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_req_i && !rd_fetch_i && rd_prot == fpc_pkg::protect_exec_only |=>
		rd_blocked_o && !rd_valid_o && irq_raw_o[1])
		else $error("exec-only data read not blocked");
	a_done_on_end: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		busy_o ##1 !busy_o |-> irq_raw_o[0])
		else $error("done flag missing after operation");
	a_mask_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		irq_o |-> (irq_raw_o[0] && done_irq_mask_bit) || (irq_raw_o[1] && violation_irq_mask_bit))
		else $error("interrupt not gated by mask");
	a_clear_done: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		irq_clear_i[0] && !op_end |=> !irq_raw_o[0])
		else $error("done flag not cleared");
	a_commit_sticky: assert property (@(posedge clk_sys_i)
		prot_committed_o |=> prot_committed_o)
		else $error("commit reverted");
	// a program pulse stays busy at least 9 clocks, whatever the loaded rate
	a_prog_time: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		cmd_go && prog_req_i |=> busy_o [*8] ##1 busy_o)
		else $error("program pulse ended early");
	a_prog_and: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		op_end && state_reg == fpc_pkg::FPC_PROG |=> mem[op_addr_reg] == ($past(mem[op_addr_reg]) & op_data_reg))
		else $error("program set a bit");

	// ----------------------------------------
	// checks: array, reads, flags, rate, commit and busy
	// ----------------------------------------
	// word next to the programmed one, same block
	wire logic [fpc_pkg::WADDR_W-1:0] nbr_word = {op_addr_reg[fpc_pkg::WADDR_W-1:1],
	                                               ~op_addr_reg[0]};
	a_prog_word: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		op_end && state_reg == fpc_pkg::FPC_PROG |=> $stable(mem[nbr_word]))
		else $error("program touched a second word");
	a_erase_ones: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		op_end && state_reg == fpc_pkg::FPC_ERASE |=>
		mem[op_addr_reg] == fpc_pkg::ERASED_WORD)
		else $error("erased word not all ones");
	a_done_set: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		op_end |=> irq_raw_o[fpc_pkg::DONE_BIT] && !busy_o)
		else $error("operation end without done flag");
	a_done_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		irq_raw_o[fpc_pkg::DONE_BIT] && !irq_clear_i[fpc_pkg::DONE_BIT] |=>
		irq_raw_o[fpc_pkg::DONE_BIT])
		else $error("done flag dropped without clear");
	a_viol_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		irq_raw_o[fpc_pkg::VIOL_BIT] && !irq_clear_i[fpc_pkg::VIOL_BIT] |=>
		irq_raw_o[fpc_pkg::VIOL_BIT])
		else $error("violation flag dropped without clear");
	a_clear_viol: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		irq_clear_i[fpc_pkg::VIOL_BIT] && !cmd_viol && !rd_inval |=>
		!irq_raw_o[fpc_pkg::VIOL_BIT])
		else $error("violation flag not cleared");
	a_rd_answer: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_req_i && !rd_deny |=> rd_valid_o && !rd_blocked_o)
		else $error("allowed read not served");
	a_exec_fetch: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_req_i && rd_fetch_i && rd_prot == fpc_pkg::protect_exec_only |=>
		rd_valid_o && !rd_blocked_o)
		else $error("fetch from exec-only region refused");
	a_rd_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_deny |=> rd_data_o == 32'h0000_0000)
		else $error("blocked read returned data");
	a_usec_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		busy_o |=> $stable(usec_clocks_o))
		else $error("clock rate changed during pulse");
	a_commit_keep: assert property (@(posedge clk_sys_i)
		prot_committed_o && !resetn_i |=> $stable(prot_o))
		else $error("committed protection lost in reset");
	a_busy_after_go: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		cmd_go |=> busy_o)
		else $error("accepted command not busy");
	a_idle_quiet: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!busy_o && !cmd_go |=> !busy_o)
		else $error("busy without accepted command");
endmodule : fpc_ctrl
`default_nettype wire

// *** fpc_pkg.sv ***
// fpc_pkg: constants for the flash program/erase/protect controller
// assumes: single system clock domain, synchronous active-low reset
package fpc_pkg;
	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int          ADDR_W       = 14;          // byte address, 16 kB array
	localparam int          WORDS        = 4096;
	localparam int          WADDR_W      = 12;          // word address width
	localparam int          ERASE_LSB    = 8;           // 1 kB block: word addr [11:8]
	localparam int          PROT_LSB     = 9;           // 2 kB region: word addr [11:9]
	localparam int          REGIONS      = 8;
	localparam int          REG_W        = 3;
	localparam logic [31:0] ERASED_WORD  = 32'hffff_ffff;
	// ----------------------------------------
	// protection encoding, ordered by strictness
	// ----------------------------------------
	typedef enum logic [1:0] {
		protect_read_write = 2'b00,
		protect_read_only  = 2'b01,
		protect_exec_only  = 2'b10
	} fpc_prot_e;
	// ----------------------------------------
	// interrupt bit positions
	// ----------------------------------------
	localparam int DONE_BIT = 0;
	localparam int VIOL_BIT = 1;
	// ----------------------------------------
	// pulse times in microseconds
	// ----------------------------------------
	localparam logic [15:0] PROG_US  = 16'h0014;        // 20 us
	localparam logic [15:0] ERASE_US = 16'h0064;        // 100 us
	localparam logic [7:0]  USEC_RST = 8'h64;           // 100 clocks/us at 100 MHz
	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		FPC_IDLE  = 2'b00,
		FPC_PROG  = 2'b01,
		FPC_ERASE = 2'b10
	} fpc_state_e;
endpackage : fpc_pkg

// *** testbench.sv ***
// testbench: random and corner-case checks of fpc_ctrl through a core model
// assumes: fpc_pkg, fpc_ctrl and fpc_core_model compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %s expected %h seen %h", n, e, g); end end
module testbench;
	logic             clk_sys_i, resetn_i, mdone, mviol;
	int unsigned      fails, check_count;
	wire logic [7:0]  usw, uso;
	wire logic [13:0] ca, ra;
	wire logic [31:0] pd, rdd;
	wire logic [15:0] prot;
	wire logic [2:0]  preg;
	wire logic [1:0]  pval, clr, raw, msk;
	wire logic        ul, pr, er, busy, rr, rf, rv, rb, ps, pc, pcm, irq;
	fpc_core_model core (.clk_sys_i(clk_sys_i), .usec_o(usw), .usec_ld_o(ul), .prog_o(pr),
		.erase_o(er), .addr_o(ca), .data_o(pd), .rd_o(rr), .fetch_o(rf), .raddr_o(ra),
		.pset_o(ps), .preg_o(preg), .pval_o(pval), .commit_o(pc), .clr_o(clr));
	fpc_ctrl DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .usec_clocks_i(usw),
		.usec_load_i(ul), .usec_clocks_o(uso), .prog_req_i(pr), .erase_req_i(er),
		.cmd_addr_i(ca), .prog_data_i(pd), .busy_o(busy), .rd_req_i(rr), .rd_fetch_i(rf),
		.rd_addr_i(ra), .rd_data_o(rdd), .rd_valid_o(rv), .rd_blocked_o(rb),
		.prot_set_i(ps), .prot_region_i(preg), .prot_value_i(pval), .prot_commit_i(pc),
		.prot_o(prot), .prot_committed_o(pcm), .irq_clear_i(clr),
		.done_irq_mask_bit(mdone), .violation_irq_mask_bit(mviol), .irq_raw_o(raw),
		.irq_masked_o(msk), .irq_o(irq));
	function automatic int unsigned plen(input logic [15:0] us, input logic [7:0] u);
		return us * ((u == 8'h00) ? 1 : u);
	endfunction : plen
	function automatic logic [31:0] aprog(input logic [31:0] old, input logic [31:0] d);
		return old & d;
	endfunction : aprog
	task automatic summarize();
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task automatic do_reset();
		@(negedge clk_sys_i);
		resetn_i = 1'b0;
		repeat (8) @(negedge clk_sys_i);
		resetn_i = 1'b1;
		`CHK("rst_busy", 1'b0, busy)
		`CHK("rst_irq", 2'b00, raw)
	endtask : do_reset
	task automatic finish_op(input int unsigned exp);
		int unsigned cnt;
		cnt = 0;
		while (busy === 1'b1 && cnt < 5000) begin
			cnt++;
			@(negedge clk_sys_i);
		end
		`CHK("busy_len", exp, cnt)
		@(negedge clk_sys_i);
		`CHK("done_raw", 2'b01, raw)
		`CHK("done_irq", mdone, irq)
		`CHK("done_mask", {1'b0, mdone}, msk)
		core.clear(2'b01);
		`CHK("done_clr", 2'b00, raw)
	endtask : finish_op
	task automatic viol_chk();
		@(negedge clk_sys_i);
		`CHK("viol_raw", 2'b10, raw)
		`CHK("viol_mask", 2'b10, msk)
		`CHK("viol_irq", 1'b1, irq)
		core.clear(2'b10);
		`CHK("viol_clr", 2'b00, raw)
	endtask : viol_chk
	task automatic rd_chk(input logic f, input logic [13:0] a, input logic v, input logic [31:0] d);
		core.rd(f, a);
		`CHK("rd_valid", v, rv)
		`CHK("rd_block", !v, rb)
		`CHK("rd_data", d, rdd)
	endtask : rd_chk
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [7:0]  u;
		logic [13:0] a;
		logic [31:0] d1, d2;
		{resetn_i, mdone, mviol, fails, check_count} = '0;
		void'($urandom(28));
		do_reset();
		`CHK("usec_rst", fpc_pkg::USEC_RST, uso)
		`CHK("prot_rst", 16'h0000, prot)
		u = 8'(1 + $urandom % 3);
		core.usec(u);
		`CHK("usec_load", u, uso)
		for (int k = 0; k < 5; k++) begin
			core.cmd(1'b1, 14'(k * 1024), 32'h0);
			finish_op(plen(fpc_pkg::ERASE_US, u));
		end
		for (int i = 0; i < 8; i++) begin
			a = 14'(i * 256 + ($urandom % 63) * 4);
			d1 = $urandom;
			d2 = $urandom;
			mdone = i[0];
			rd_chk(1'b0, a, 1'b1, fpc_pkg::ERASED_WORD);
			core.cmd(1'b0, a, d1);
			finish_op(plen(fpc_pkg::PROG_US, u));
			core.cmd(1'b0, a, d2);
			finish_op(plen(fpc_pkg::PROG_US, u));
			rd_chk(1'b0, a, 1'b1, aprog(aprog(fpc_pkg::ERASED_WORD, d1), d2));
			rd_chk(1'b0, a + 14'h0004, 1'b1, fpc_pkg::ERASED_WORD);
		end
		core.cmd(1'b0, 14'h07fc, 32'h0);
		finish_op(plen(fpc_pkg::PROG_US, u));
		core.cmd(1'b1, 14'h0000, 32'h0);
		core.cmd(1'b0, 14'h0000, 32'h0);
		finish_op(plen(fpc_pkg::ERASE_US, u) - 2);
		rd_chk(1'b0, 14'h07fc, 1'b1, 32'h0);
		rd_chk(1'b0, 14'h0000, 1'b1, fpc_pkg::ERASED_WORD);
		mviol = 1'b1;
		core.prot(1'b1, 3'd2, fpc_pkg::protect_read_only);
		`CHK("prot_now", 2'b01, prot[5:4])
		do_reset();
		`CHK("prot_temp", 16'h0000, prot)
		core.usec(u);
		core.prot(1'b1, 3'd0, fpc_pkg::protect_read_only);
		core.prot(1'b1, 3'd0, fpc_pkg::protect_read_write);
		core.prot(1'b1, 3'd1, fpc_pkg::protect_exec_only);
		core.prot(1'b1, 3'd1, fpc_pkg::protect_read_only);
		`CHK("prot_tight", 4'b1001, prot[3:0])
		core.prot(1'b1, 3'd3, 2'b11);
		`CHK("prot_code", 2'b00, prot[7:6])
		for (int k = 0; k < 4; k++) begin
			core.cmd(k[0], k[1] ? 14'h0800 : 14'h0010, 32'h0);
			`CHK("refused", 1'b0, busy)
			viol_chk();
		end
		rd_chk(1'b0, 14'h0010, 1'b1, fpc_pkg::ERASED_WORD);
		rd_chk(1'b1, 14'h0010, 1'b1, fpc_pkg::ERASED_WORD);
		rd_chk(1'b1, 14'h0800, 1'b1, fpc_pkg::ERASED_WORD);
		rd_chk(1'b0, 14'h0800, 1'b0, 32'h0);
		viol_chk();
		d1 = $urandom;
		core.cmd(1'b0, 14'h1000, d1);
		finish_op(plen(fpc_pkg::PROG_US, u));
		rd_chk(1'b0, 14'h1000, 1'b1, aprog(fpc_pkg::ERASED_WORD, d1));
		core.prot(1'b0, 3'd0, 2'b00);
		`CHK("committed", 1'b1, pcm)
		do_reset();
		`CHK("prot_kept", 4'b1001, prot[3:0])
		summarize();
	end
	// a hang past 50k cycles ends the run as a mismatch
	initial begin
		#500000;
		fails++;
		summarize();
	end
endmodule : testbench
`default_nettype wire
